/* File: logic/alpr_defs.svh */
// addresses, bit positions and reset values of the partner ability words
`ifndef ALPR_DEFS_SVH
`define ALPR_DEFS_SVH
`define ALPR_DEVAD          5'h07
`define ALPR_LOW_ADDR       16'h0205
`define ALPR_MID_ADDR       16'h0206
`define ALPR_HIGH_ADDR      16'h0207
`define ALPR_WORD_RESET     16'h0000
`define ALPR_MID_MASK       16'h40F0
`define ALPR_HIGH_MASK      16'h7800
`define ALPR_MID_B10L       14
`define ALPR_MID_B1000      7
`define ALPR_MID_B10S_FD    6
`define ALPR_MID_B100       5
`define ALPR_MID_MASTER     4
`define ALPR_HIGH_EEE       14
`define ALPR_HIGH_HL_ABLE   13
`define ALPR_HIGH_HL_REQ    12
`define ALPR_HIGH_B10S_HD   11
`endif

/* File: logic/alpr_pkg.sv */
// types shared by the partner ability register bank
`default_nettype none
package alpr_pkg;
    typedef struct packed {
        logic partner_long_reach_10m_able;
        logic partner_gigabit_t1_able;
        logic partner_short_reach_full_duplex_able;
        logic partner_fast_t1_able;
        logic partner_master_pref;
        logic partner_energy_saving_able;
        logic partner_high_level_tx_able;
        logic partner_high_level_tx_request;
        logic partner_short_reach_half_duplex_able;
    } alpr_page_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  devad;
        logic [15:0] regad;
        logic [15:0] wdata;
    } alpr_mgmt_req_t;
endpackage : alpr_pkg
`default_nettype wire

/* File: logic/alpr_snap_word.sv */
// one 16-bit snapshot word loaded on a capture strobe
`timescale 1ns/100ps
`default_nettype none
`include "alpr_defs.svh"
module alpr_snap_word (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        capture,
    input  wire logic [15:0] live,
    output var  logic [15:0] word
);
    logic [15:0] next_word;

    always_comb begin
        next_word = word;
        if (capture) begin
            next_word = live;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word <= `ALPR_WORD_RESET;
        end else begin
            word <= next_word;
        end
    end
endmodule : alpr_snap_word
`default_nettype wire

/* File: logic/alpr_regs.sv */
// partner ability mid/high words with snapshot on low-word read
`timescale 1ns/100ps
`default_nettype none
`include "alpr_defs.svh"
module alpr_regs (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire alpr_pkg::alpr_page_t    PAGE_RX,
    input  wire alpr_pkg::alpr_mgmt_req_t MGMT_REQ,
    output var  logic                    MGMT_ACK,
    output var  logic [15:0]             MGMT_RDATA
);
    logic [15:0] mid_live;
    logic [15:0] high_live;
    logic [15:0] partner_ability_mid_word;
    logic [15:0] partner_ability_high_word;
    logic        dev_hit;
    logic        capture;
    logic        rd_mid;
    logic        rd_high;
    logic        next_ack;
    logic [15:0] next_rdata;

    // live page mapped to word positions; reserved positions stay zero
    always_comb begin
        mid_live  = `ALPR_WORD_RESET;
        high_live = `ALPR_WORD_RESET;
        mid_live[`ALPR_MID_B10L]    = PAGE_RX.partner_long_reach_10m_able;
        mid_live[`ALPR_MID_B1000]   = PAGE_RX.partner_gigabit_t1_able;
        mid_live[`ALPR_MID_B10S_FD] = PAGE_RX.partner_short_reach_full_duplex_able;
        mid_live[`ALPR_MID_B100]    = PAGE_RX.partner_fast_t1_able;
        mid_live[`ALPR_MID_MASTER]  = PAGE_RX.partner_master_pref;
        high_live[`ALPR_HIGH_EEE]     = PAGE_RX.partner_energy_saving_able;
        high_live[`ALPR_HIGH_HL_ABLE] = PAGE_RX.partner_high_level_tx_able;
        high_live[`ALPR_HIGH_HL_REQ]  = PAGE_RX.partner_high_level_tx_request;
        high_live[`ALPR_HIGH_B10S_HD] = PAGE_RX.partner_short_reach_half_duplex_able;
    end

    // the low word itself lives elsewhere; only its read strobe is used here
    always_comb begin
        dev_hit = (MGMT_REQ.devad == `ALPR_DEVAD);
        capture = MGMT_REQ.rd && dev_hit && (MGMT_REQ.regad == `ALPR_LOW_ADDR);
        rd_mid  = MGMT_REQ.rd && dev_hit && (MGMT_REQ.regad == `ALPR_MID_ADDR);
        rd_high = MGMT_REQ.rd && dev_hit && (MGMT_REQ.regad == `ALPR_HIGH_ADDR);
    end

    // both words share one strobe so mid and high always form one page
    alpr_snap_word u_mid (
        .clk     (CLK),
        .rst_n   (RST_N),
        .capture (capture),
        .live    (mid_live),
        .word    (partner_ability_mid_word)
    );

    alpr_snap_word u_high (
        .clk     (CLK),
        .rst_n   (RST_N),
        .capture (capture),
        .live    (high_live),
        .word    (partner_ability_high_word)
    );

    // writes are not decoded at all: read-only words
    always_comb begin
        next_ack   = rd_mid || rd_high;
        next_rdata = MGMT_RDATA;
        if (rd_mid) begin
            next_rdata = partner_ability_mid_word;
        end else if (rd_high) begin
            next_rdata = partner_ability_high_word;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MGMT_ACK   <= 1'b0;
            MGMT_RDATA <= `ALPR_WORD_RESET;
        end else begin
            MGMT_ACK   <= next_ack;
            MGMT_RDATA <= next_rdata;
        end
    end

    property p_capture_mid;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> partner_ability_mid_word == $past(mid_live);
    endproperty
    a_capture_mid: assert property (p_capture_mid)
        else $error("mid word not captured on low read");

    property p_hold_snapshot;
        @(posedge CLK) disable iff (!RST_N)
        !capture |=> $stable(partner_ability_mid_word) && $stable(partner_ability_high_word);
    endproperty
    a_hold_snapshot: assert property (p_hold_snapshot)
        else $error("snapshot changed without low read");

    property p_read_mid;
        @(posedge CLK) disable iff (!RST_N)
        rd_mid |=> MGMT_ACK && MGMT_RDATA == $past(partner_ability_mid_word);
    endproperty
    a_read_mid: assert property (p_read_mid)
        else $error("mid read returned wrong data");

    property p_read_high;
        @(posedge CLK) disable iff (!RST_N)
        rd_high |=> MGMT_ACK && MGMT_RDATA == $past(partner_ability_high_word);
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("high read returned wrong data");

    property p_reset_zero;
        @(posedge CLK)
        !RST_N |=> partner_ability_mid_word == 16'h0000 && partner_ability_high_word == 16'h0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("words not zero after reset");

    property p_mid_b10l;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> partner_ability_mid_word[14] == $past(PAGE_RX.partner_long_reach_10m_able);
    endproperty
    a_mid_b10l: assert property (p_mid_b10l)
        else $error("long reach bit wrong");

    property p_mid_speeds;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> partner_ability_mid_word[7:4] == {$past(PAGE_RX.partner_gigabit_t1_able),
            $past(PAGE_RX.partner_short_reach_full_duplex_able),
            $past(PAGE_RX.partner_fast_t1_able), $past(PAGE_RX.partner_master_pref)};
    endproperty
    a_mid_speeds: assert property (p_mid_speeds)
        else $error("mid speed or master bits wrong");

    property p_high_bits;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> partner_ability_high_word[14:11] == {
            $past(PAGE_RX.partner_energy_saving_able),
            $past(PAGE_RX.partner_high_level_tx_able),
            $past(PAGE_RX.partner_high_level_tx_request),
            $past(PAGE_RX.partner_short_reach_half_duplex_able)};
    endproperty
    a_high_bits: assert property (p_high_bits)
        else $error("high word bits wrong");

    property p_reserved_zero;
        @(posedge CLK) disable iff (!RST_N)
        (partner_ability_mid_word & ~16'h40F0) == 16'h0000
            && (partner_ability_high_word & ~16'h7800) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_write_ignored;
        @(posedge CLK) disable iff (!RST_N)
        MGMT_REQ.wr && !capture |=> $stable(partner_ability_mid_word)
            && $stable(partner_ability_high_word) && !MGMT_ACK;
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write affected read-only word");

    property p_capture_high;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> partner_ability_high_word == $past(high_live);
    endproperty
    a_capture_high: assert property (p_capture_high)
        else $error("high word not captured on low read");

    property p_low_read_quiet;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> !MGMT_ACK && $stable(MGMT_RDATA);
    endproperty
    a_low_read_quiet: assert property (p_low_read_quiet)
        else $error("low word read answered by this bank");

    property p_ack_only_read;
        @(posedge CLK) disable iff (!RST_N)
        !(rd_mid || rd_high) |=> !MGMT_ACK;
    endproperty
    a_ack_only_read: assert property (p_ack_only_read)
        else $error("ack without a mid or high read");

    property p_rdata_hold;
        @(posedge CLK) disable iff (!RST_N)
        !(rd_mid || rd_high) |=> $stable(MGMT_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    property p_ack_cause;
        @(posedge CLK) disable iff (!RST_N)
        MGMT_ACK |-> $past(next_ack);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack not caused by a read");

    property p_foreign_dev;
        @(posedge CLK) disable iff (!RST_N)
        MGMT_REQ.rd && !dev_hit |=> !MGMT_ACK && $stable(MGMT_RDATA);
    endproperty
    a_foreign_dev: assert property (p_foreign_dev)
        else $error("other device read answered");

    property p_reset_outputs;
        @(posedge CLK)
        !RST_N |=> !MGMT_ACK && MGMT_RDATA == `ALPR_WORD_RESET;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("answer port not cleared by reset");

    property p_mid_rdata_reserved;
        @(posedge CLK) disable iff (!RST_N)
        rd_mid |=> (MGMT_RDATA & ~`ALPR_MID_MASK) == `ALPR_WORD_RESET;
    endproperty
    a_mid_rdata_reserved: assert property (p_mid_rdata_reserved)
        else $error("mid read shows reserved bit");

    property p_high_rdata_reserved;
        @(posedge CLK) disable iff (!RST_N)
        rd_high |=> (MGMT_RDATA & ~`ALPR_HIGH_MASK) == `ALPR_WORD_RESET;
    endproperty
    a_high_rdata_reserved: assert property (p_high_rdata_reserved)
        else $error("high read shows reserved bit");
endmodule : alpr_regs
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the partner ability snapshot words
`timescale 1ns/100ps
`default_nettype none
`include "alpr_defs.svh"
module tb_top;
    typedef struct packed {
        logic [8:0]  page;
        logic [15:0] mid;
        logic [15:0] high;
    } alpr_row_t;

    logic                     clk;
    logic                     rst_n;
    alpr_pkg::alpr_page_t     page_rx;
    alpr_pkg::alpr_mgmt_req_t req;
    logic                     ack;
    logic [15:0]              rdata;
    logic                     got_ack;
    logic [15:0]              got_data;
    int                       n_errors;
    int                       num_checks;
    alpr_row_t                rows [6];

    alpr_regs u_alpr_regs (
        .CLK        (clk),
        .RST_N      (rst_n),
        .PAGE_RX    (page_rx),
        .MGMT_REQ   (req),
        .MGMT_ACK   (ack),
        .MGMT_RDATA (rdata)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one request per falling edge; answer sampled at the next falling edge, half a cycle after the taking edge
    task automatic op(input logic rd, input logic wr, input logic [4:0] dev,
                      input logic [15:0] ad, input logic [15:0] wd);
        req = '{rd, wr, dev, ad, wd};
        @(negedge clk);
        got_ack = ack;
        got_data = rdata;
    endtask : op

    // rdata is compared even without ack, since it must hold its last value
    task automatic rd_chk(input logic [15:0] ad, input logic a, input logic [15:0] d);
        op(1'b1, 1'b0, `ALPR_DEVAD, ad, 16'h0000);
        chk({15'h0000, got_ack}, {15'h0000, a});
        chk(got_data, d);
    endtask : rd_chk

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is well under 200 cycles
    initial begin
        #40000;
        n_errors++;
        close_out();
    end

    initial begin
        rows[0] = '{9'h1FF, 16'h40F0, 16'h7800};
        rows[1] = '{9'h000, 16'h0000, 16'h0000};
        rows[2] = '{9'h0AA, 16'h00A0, 16'h5000};
        rows[3] = '{9'h010, 16'h0010, 16'h0000};
        rows[4] = '{9'h001, 16'h0000, 16'h0800};
        rows[5] = '{9'h155, 16'h4050, 16'h2800};
        n_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        page_rx = 9'h1FF;
        req = '0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`ALPR_MID_ADDR, 1'b1, 16'h0000);
        rd_chk(`ALPR_HIGH_ADDR, 1'b1, 16'h0000);
        foreach (rows[i]) begin
            page_rx = rows[i].page;
            op(1'b1, 1'b0, `ALPR_DEVAD, `ALPR_LOW_ADDR, 16'h0000);
            chk({15'h0000, got_ack}, 16'h0000);
            // live bits flip so a live read would differ from the snapshot
            page_rx = ~rows[i].page;
            rd_chk(`ALPR_MID_ADDR, 1'b1, rows[i].mid);
            rd_chk(`ALPR_HIGH_ADDR, 1'b1, rows[i].high);
        end
        page_rx = 9'h0AA;
        op(1'b0, 1'b1, `ALPR_DEVAD, `ALPR_MID_ADDR, 16'hFFFF);
        chk({15'h0000, got_ack}, 16'h0000);
        op(1'b0, 1'b1, `ALPR_DEVAD, `ALPR_LOW_ADDR, 16'hFFFF);
        rd_chk(`ALPR_MID_ADDR, 1'b1, 16'h4050);
        rd_chk(16'h0208, 1'b0, 16'h4050);
        op(1'b1, 1'b0, 5'h01, `ALPR_LOW_ADDR, 16'h0000);
        rd_chk(`ALPR_HIGH_ADDR, 1'b1, 16'h2800);
        op(1'b1, 1'b0, `ALPR_DEVAD, `ALPR_LOW_ADDR, 16'h0000);
        rst_n = 1'b0;
        req = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`ALPR_MID_ADDR, 1'b1, 16'h0000);
        rd_chk(`ALPR_HIGH_ADDR, 1'b1, 16'h0000);
        op(1'b1, 1'b0, 5'h00, `ALPR_MID_ADDR, 16'h0000);
        chk({15'h0000, got_ack}, 16'h0000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
